// [design/tcm_pkg.sv]
// Constants and carriers for the T1 transmit common control block.
// Assumes a byte-wide framer datapath with channel numbers 0..23.
package tcm_pkg;
  localparam int NCH       = 24;
  localparam int HIST_BITS = 192;           // 8 x (23 + 1)
  localparam int MAX_ZEROS = 15;
  localparam int DENS_NMAX = 23;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CCR   = 8'h07;
  localparam logic [7:0] IDX_MW0   = 8'h0C;
  localparam logic [7:0] IDX_MW1   = 8'h0D;
  localparam logic [7:0] IDX_MW2   = 8'h0E;
  localparam logic [7:0] IDX_INFO  = 8'h10;
  localparam logic [7:0] IDX_AUX   = 8'h20;
  localparam logic [7:0] IDX_SSIE0 = 8'h21;
  localparam logic [7:0] IDX_SSIE1 = 8'h22;
  localparam logic [7:0] IDX_SSIE2 = 8'h23;
  localparam logic [7:0] IDX_LPA   = 8'h24;
  localparam logic [7:0] IDX_LPB   = 8'h25;
  localparam logic [7:0] IDX_ST4   = 8'h26;
  localparam logic [7:0] IDX_SIG0  = 8'h28;  // six registers, four channels each
  localparam logic [7:0] IDX_SIG5  = 8'h2D;

  // Field positions
  localparam int CCR_LOOP = 0;
  localparam int CCR_PDE  = 1;
  localparam int CCR_TFM  = 2;
  localparam int CCR_AIS  = 3;
  localparam int CCR_RAI  = 4;
  localparam int AUX_YEL  = 0;
  localparam int AUX_BLUE = 1;
  localparam int AUX_GB   = 2;
  localparam int AUX_ZS   = 3;
  localparam int AUX_SIG  = 4;
  localparam int INF_TPDV = 6;
  localparam int INF_RPDV = 7;
  localparam int ST4_AIS  = 0;
  localparam int ST4_RAI  = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] HIST_RST = 8'hFF;   // history starts as ones: no false flag

  // Patterns
  localparam logic [7:0]  MW_PAT [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                         8'h9E, 8'h8B, 8'h8B, 8'h9E};
  localparam logic [5:0]  RAICI_BOC  = 6'h1F;       // 011111
  localparam logic [15:0] BOC_WORD   = {2'h0, RAICI_BOC, 8'hFF};
  localparam logic [7:0]  AISCI_BYTE = 8'h7C;       // marker byte, plain default
  localparam logic [7:0]  AISCI_PER  = 8'hC0;       // bytes between markers
  localparam logic [7:0]  ENF_MASK   = 8'h81;
  localparam logic [7:0]  ALL_ONES   = 8'hFF;
  localparam logic [1:0]  SIG_A      = 2'h1;
  localparam logic [1:0]  SIG_B      = 2'h2;

  // One payload byte with its slot number and robbed-bit frame phase
  typedef struct packed {
    logic [7:0] data;
    logic [4:0] chan;
    logic [1:0] sig;
  } tcm_byte_t;
endpackage : tcm_pkg

// [design/tcm_top.sv]
// Transmit common control, density monitor/enforcer and rx milliwatt.
// Assumes one byte per valid cycle, channel 0..23 payload, 24+ F slot.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// - Loop enable replaces outgoing data with the two loop pattern bytes.
// - Both streams are checked for more than 15 consecutive zeros.
// - Windows of 8x(N+1) bits with fewer than N ones are flagged.
// - Transmit violations go to info bit 6, receive to bit 7.
// - Enforcer bit adds ones so outgoing data meets density.
// - Control bit 2 chooses D4 (0) or ESF (1) framing.
// - AIS-CI goes out only when bit 3 and blue alarm are set.
// - Control bit 4 sends the ESF RAI-CI code in FDL slots.
// - Enabled channels take signaling bits from the signaling registers.
// - Clear channels get no robbed bits and no bit 7 stuffing.
// - D4 yellow alarm zeroes bit 2 even in clear channels.
// - Global stuff plus zero suppress stuffs all 24 channels.
// - Received ESF RAI-CI is yellow plus message 011111.
// - A status bit rises when incoming AIS-CI is recognised.
// - Milliwatt pattern is 1E 0B 0B 1E 9E 8B 8B 9E cyclic.
// - Three enable registers map channels 1..24 from bit 0 upward.
// - Enabled receive channels are replaced by the milliwatt pattern.
// - Blue alarm sends unframed all ones instead of data.
// - Info bit 6 flags transmit density failure, like bit 7 receive.
module tcm_top
  import tcm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Transmit stream
  input  wire logic        tx_valid_i,
  input  wire tcm_byte_t   tx_in_i,
  input  wire logic        tx_fdl_slot_i,
  output logic             tx_valid_o,
  output tcm_byte_t        tx_out_o,
  output logic             tx_fdl_bit_o,
  // Receive stream
  input  wire logic        rx_valid_i,
  input  wire tcm_byte_t   rx_in_i,
  input  wire logic        rx_blue_i,
  input  wire logic        rx_yellow_i,
  input  wire logic [5:0]  rx_boc_i,
  output logic             rx_valid_o,
  output tcm_byte_t        rx_out_o
);

  logic [4:0]           ccr_r;
  logic [NCH-1:0]       mw_r;
  logic [4:0]           aux_r;
  logic [NCH-1:0]       ssie_r;
  logic [7:0]           lpa_r;
  logic [7:0]           lpb_r;
  logic [NCH-1:0][1:0]  sig_r;
  logic [7:0]           info_r;
  logic [1:0]           st4_r;
  logic [HIST_BITS-1:0] thist_r;
  logic [HIST_BITS-1:0] rhist_r;
  logic                 lp_sel_r;
  logic [7:0]           ais_cnt_r;
  logic [3:0]           fdl_idx_r;
  logic [2:0]           mw_idx_r;

  // Density rules over a history whose bit 0 is the newest bit
  function automatic logic dens_bad(input logic [HIST_BITS-1:0] h);
    int  ones;
    logic bad;
    ones = 0;
    bad  = 1'b0;
    for (int i = 0; i < HIST_BITS; i++) begin
      ones = ones + int'(h[i]);
      if (((i + 1) % 8 == 0) && (i >= 15) && (ones < (i + 1) / 8 - 1)) begin
        bad = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (h[j +: MAX_ZEROS + 1] == '0) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : dens_bad

  // Register index decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] ix);
    return (ix == IDX_CCR) || (ix >= IDX_MW0 && ix <= IDX_MW2) ||
           (ix == IDX_INFO) || (ix >= IDX_AUX && ix <= IDX_ST4) ||
           (ix >= IDX_SIG0 && ix <= IDX_SIG5);
  endfunction : mapped

  // APB: one wait state, write and read both land with pready
  logic [7:0] idx;
  logic       acc;
  logic       wr;
  assign idx = paddr_i[9:2];
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr  = psel_i & penable_i & pready_o & pwrite_i & mapped(idx) & ~(|paddr_i[11:10]);

  // Read data mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = RST_BYTE;
    case (idx)
      IDX_CCR:   rd_byte = {3'h0, ccr_r};
      IDX_MW0:   rd_byte = mw_r[7:0];
      IDX_MW1:   rd_byte = mw_r[15:8];
      IDX_MW2:   rd_byte = mw_r[23:16];
      IDX_INFO:  rd_byte = info_r;
      IDX_AUX:   rd_byte = {3'h0, aux_r};
      IDX_SSIE0: rd_byte = ssie_r[7:0];
      IDX_SSIE1: rd_byte = ssie_r[15:8];
      IDX_SSIE2: rd_byte = ssie_r[23:16];
      IDX_LPA:   rd_byte = lpa_r;
      IDX_LPB:   rd_byte = lpb_r;
      IDX_ST4:   rd_byte = {6'h00, st4_r};
      default: begin
        if (idx >= IDX_SIG0 && idx <= IDX_SIG5) begin
          rd_byte = sig_r[(idx - IDX_SIG0) * 4 +: 4];
        end
      end
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (ce_i) begin
      pready_o  <= acc;
      pslverr_o <= acc & (~mapped(idx) | (|paddr_i[11:10]));
      prdata_o  <= (acc & ~pwrite_i & mapped(idx)) ? {24'h0, rd_byte} : '0;
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ccr_r  <= '0;
      mw_r   <= '0;
      aux_r  <= '0;
      ssie_r <= '0;
      lpa_r  <= RST_BYTE;
      lpb_r  <= RST_BYTE;
      sig_r  <= '0;
    end else if (ce_i && wr) begin
      case (idx)
        IDX_CCR:   ccr_r         <= pwdata_i[4:0];  // upper bits kept zero
        IDX_MW0:   mw_r[7:0]     <= pwdata_i[7:0];
        IDX_MW1:   mw_r[15:8]    <= pwdata_i[7:0];
        IDX_MW2:   mw_r[23:16]   <= pwdata_i[7:0];
        IDX_AUX:   aux_r         <= pwdata_i[4:0];
        IDX_SSIE0: ssie_r[7:0]   <= pwdata_i[7:0];
        IDX_SSIE1: ssie_r[15:8]  <= pwdata_i[7:0];
        IDX_SSIE2: ssie_r[23:16] <= pwdata_i[7:0];
        IDX_LPA:   lpa_r         <= pwdata_i[7:0];
        IDX_LPB:   lpb_r         <= pwdata_i[7:0];
        default: begin
          if (idx >= IDX_SIG0 && idx <= IDX_SIG5) begin
            sig_r[(idx - IDX_SIG0) * 4 +: 4] <= pwdata_i[7:0];
          end
        end
      endcase
    end
  end

  // Transmit byte processing, stage by stage
  logic [4:0] tc;
  logic       tpay;
  logic       tstuff;
  logic       tclear;
  logic [7:0] td;
  logic       tviol;
  always_comb begin
    tc     = tx_in_i.chan;
    tpay   = (tc < 5'(NCH));
    td     = tx_in_i.data;
    tstuff = 1'b0;
    tclear = 1'b1;
    if (tpay) begin
      tclear = ~ssie_r[tc] & ~aux_r[AUX_GB];
      tstuff = aux_r[AUX_ZS] & ~tclear;
      if (tstuff && td == 8'h00) begin
        td[1] = 1'b1;                                       // bit 7 stuffing
      end
      if (aux_r[AUX_SIG] && ssie_r[tc]) begin
        if (tx_in_i.sig == SIG_A) td[0] = sig_r[tc][0];
        if (tx_in_i.sig == SIG_B) td[0] = sig_r[tc][1];
      end
      if (aux_r[AUX_YEL] && !ccr_r[CCR_TFM]) begin
        td[6] = 1'b0;
      end
      if (ccr_r[CCR_LOOP]) begin
        td = lp_sel_r ? lpb_r : lpa_r;
      end
      if (ccr_r[CCR_PDE] && dens_bad({thist_r[HIST_BITS-9:0], td})) begin
        td = td | ENF_MASK;
      end
    end
    if (aux_r[AUX_BLUE]) begin
      td = ALL_ONES;
      if (ccr_r[CCR_AIS] && ais_cnt_r == AISCI_PER) begin
        td = AISCI_BYTE;
      end
    end
    tviol = dens_bad({thist_r[HIST_BITS-9:0], td});
  end

  // Transmit output and history; clear channels skip only stuffing and signaling above
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_out_o   <= '0;
      thist_r    <= {(HIST_BITS / 8){HIST_RST}};
      lp_sel_r   <= 1'b0;
      ais_cnt_r  <= '0;
    end else if (ce_i) begin
      tx_valid_o <= tx_valid_i;
      if (tx_valid_i) begin
        tx_out_o  <= '{data: td, chan: tc, sig: tx_in_i.sig};
        thist_r   <= {thist_r[HIST_BITS-9:0], td};
        lp_sel_r  <= ccr_r[CCR_LOOP] & tpay & ~lp_sel_r;
        ais_cnt_r <= (ais_cnt_r == AISCI_PER) ? 8'h00 : ais_cnt_r + 8'h01;
      end
    end
  end

  // FDL bit source: RAI-CI message repeats only in ESF
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_fdl_bit_o <= 1'b1;
      fdl_idx_r    <= '0;
    end else if (ce_i && tx_fdl_slot_i) begin
      if (ccr_r[CCR_RAI] && ccr_r[CCR_TFM]) begin
        tx_fdl_bit_o <= BOC_WORD[4'hF - fdl_idx_r];
        fdl_idx_r    <= fdl_idx_r + 4'h1;
      end else begin
        tx_fdl_bit_o <= 1'b1;
        fdl_idx_r    <= '0;
      end
    end
  end

  // Receive path: milliwatt substitution toward the backplane
  logic [4:0] rc;
  logic       rsub;
  logic [7:0] rd;
  logic       rviol;
  always_comb begin
    rc    = rx_in_i.chan;
    rsub  = (rc < 5'(NCH)) && mw_r[rc];
    rd    = rsub ? MW_PAT[mw_idx_r] : rx_in_i.data;
    rviol = dens_bad({rhist_r[HIST_BITS-9:0], rx_in_i.data});
  end

  // Receive output, history, milliwatt phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_out_o   <= '0;
      rhist_r    <= {(HIST_BITS / 8){HIST_RST}};
      mw_idx_r   <= '0;
    end else if (ce_i) begin
      rx_valid_o <= rx_valid_i;
      if (rx_valid_i) begin
        rx_out_o <= '{data: rd, chan: rc, sig: rx_in_i.sig};
        rhist_r  <= {rhist_r[HIST_BITS-9:0], rx_in_i.data};
        if (rc == 5'(NCH - 1)) begin
          mw_idx_r <= mw_idx_r + 3'h1;
        end
      end
    end
  end

  // Sticky density events; write one to clear, a new event wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      info_r <= RST_BYTE;
    end else if (ce_i) begin
      if (wr && idx == IDX_INFO) begin
        info_r <= info_r & ~pwdata_i[7:0];
      end
      if (tx_valid_i && tviol) info_r[INF_TPDV] <= 1'b1;
      if (rx_valid_i && rviol) info_r[INF_RPDV] <= 1'b1;
    end
  end

  // Customer alarm status: AIS held until blue alarm drops, RAI live level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st4_r <= '0;
    end else if (ce_i) begin
      if (!rx_blue_i) begin
        st4_r[ST4_AIS] <= 1'b0;
      end else if (rx_valid_i && rx_in_i.data == AISCI_BYTE) begin
        st4_r[ST4_AIS] <= 1'b1;
      end
      st4_r[ST4_RAI] <= rx_yellow_i & (rx_boc_i == RAICI_BOC);
    end
  end

endmodule : tcm_top

// [sim/tcm_top_assertions.sv]
// Port checker for the transmit common control block.
// Assumes ce_i stays high while it watches.
`timescale 1ns/100ps
module tcm_top_assertions
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Register bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Streams
  input wire logic        tx_valid_i,
  input wire logic        tx_fdl_slot_i,
  input wire logic        tx_valid_o,
  input wire logic        tx_fdl_bit_o,
  input wire logic        rx_valid_i,
  input wire tcm_byte_t   rx_in_i,
  input wire logic        rx_valid_o,
  input wire tcm_byte_t   rx_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Bus answers after exactly one wait cycle
  a_ready_after_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready missing after wait");
  a_ready_not_setup: assert property (psel_i && !penable_i |=> !pready_o)
    else $error("ready in setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready_o || !psel_i |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  // Stream latency and slot order; a stale slot would mix channels
  a_tx_latency: assert property (1'b1 |=> tx_valid_o == $past(tx_valid_i))
    else $error("tx latency");
  a_rx_slot_kept: assert property (rx_valid_i |=> rx_valid_o && rx_out_o.chan == $past(rx_in_i.chan))
    else $error("rx slot changed");
  a_fdl_holds: assert property (!tx_fdl_slot_i |=> $stable(tx_fdl_bit_o))
    else $error("fdl bit moved");
endmodule : tcm_top_assertions

// [sim/tcm_line_model.sv]
// Far side model: line and backplane byte source, slots 0..24.
// Assumes run_i is held high for whole frames.
`timescale 1ns/100ps
module tcm_line_model
  import tcm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [7:0] dat_i,
  // Byte stream
  output logic            valid_o,
  output tcm_byte_t       byte_o
);
  // Idle data is inverted so a stale byte never looks fresh
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      byte_o  <= '0;
    end else if (run_i) begin
      valid_o     <= 1'b1;
      byte_o.data <= dat_i;
      byte_o.chan <= (valid_o && byte_o.chan < 5'h18) ? byte_o.chan + 5'h01 : 5'h00;
      byte_o.sig  <= SIG_A;  // Every frame offers A bits to the robbed-bit path
    end else begin
      valid_o     <= 1'b0;
      byte_o.data <= ~byte_o.data;
    end
  end
endmodule : tcm_line_model

// [sim/tcm_top_bench.sv]
// Self-checking bench for the transmit common control block.
// Assumes one model stream feeds both tx and rx.
`timescale 1ns/100ps
module tcm_top_bench;
  import tcm_pkg::*;
  logic        clk_i = 1'b0;
  logic        ce_i  = 1'b1;
  logic        rst_n_i, psel_i, penable_i, pwrite_i, tx_fdl_slot_i, run, err;
  logic        rx_blue_i, rx_yellow_i, pready_o, pslverr_o, tx_fdl_bit_o;
  logic        tx_valid_i, tx_valid_o, rx_valid_i, rx_valid_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [7:0]  dat;
  logic [5:0]  rx_boc_i;
  tcm_byte_t   tx_in_i, rx_in_i, tx_out_o, rx_out_o;
  int          n_errors, comparisons;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  tcm_top u_dut (.*);
  tcm_line_model u_line (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .dat_i(dat),
                         .valid_o(tx_valid_i), .byte_o(tx_in_i));
  // Both directions carry the same stream
  assign rx_valid_i = tx_valid_i;
  assign rx_in_i    = tx_in_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer; held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h0, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 20 && pready_o !== 1'b1; i++) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [7:0] aux, input logic [7:0] ccr, input logic [7:0] d);
    apb(1'b1, IDX_AUX, aux);
    apb(1'b1, IDX_CCR, ccr);
    dat <= d;
    run <= 1'b1;
    repeat (30) @(posedge clk_i);
  endtask : cfg

  task automatic t_regs;
    logic [7:0] idx [4] = '{IDX_CCR, IDX_MW0, IDX_MW1, IDX_MW2};
    foreach (idx[i]) begin
      apb(1'b0, idx[i], 8'h00);
      check(rd, 32'h0);
      apb(1'b1, idx[i], 8'hFF);
      apb(1'b0, idx[i], 8'h00);
      check(rd, (i == 0) ? 32'h1F : 32'hFF);
      apb(1'b1, idx[i], 8'h00);
    end
    apb(1'b0, 8'h3F, 8'h00);
    check({31'h0, err}, 32'h1);
    $display("Registers done");
  endtask : t_regs

  task automatic t_mw;
    int fr;
    fr = 0;
    apb(1'b1, IDX_MW0, 8'h01);
    apb(1'b1, IDX_MW2, 8'h80);
    dat <= 8'h3C;
    run <= 1'b1;
    while (fr < 9) begin
      @(negedge clk_i);
      if (rx_valid_o === 1'b1 && rx_out_o.chan < 5'h18) begin
        if (rx_out_o.chan == 5'h00 || rx_out_o.chan == 5'h17)
          check(rx_out_o.data, MW_PAT[fr % 8]);
        else
          check(rx_out_o.data, 8'h3C);
        if (rx_out_o.chan == 5'h17)
          fr++;
      end
    end
    apb(1'b1, IDX_MW0, 8'h00);
    apb(1'b1, IDX_MW2, 8'h00);
    $display("Milliwatt done");
  endtask : t_mw

  // Table rows: aux, control, data, expected payload byte
  task automatic t_tx;
    logic [31:0] tab [7] = '{32'h0800_0000, 32'h0C00_0002, 32'h0100_FFBF,
                             32'h0008_3C3C, 32'h0200_3CFF, 32'h0104_FFFF,
                             32'h0000_8B8B};
    foreach (tab[i]) begin
      cfg(tab[i][31:24], tab[i][23:16], tab[i][15:8]);
      repeat (40) begin
        @(negedge clk_i);
        if (tx_valid_o === 1'b1 && tx_out_o.chan < 5'h18)
          check(tx_out_o.data, tab[i][7:0]);
      end
    end
    $display("Transmit table done");
  endtask : t_tx

  task automatic t_ais;
    int n7c;
    int nff;
    n7c = 0;
    nff = 0;
    cfg(8'h02, 8'h08, 8'h3C);
    repeat (386) begin
      @(negedge clk_i);
      if (tx_out_o.data === AISCI_BYTE)
        n7c++;
      else if (tx_out_o.data === ALL_ONES)
        nff++;
    end
    check(32'(n7c), 32'h2);
    check(32'(nff), 32'h180);
    $display("Customer alarm done");
  endtask : t_ais

  task automatic t_loop;
    logic [7:0] prev;
    logic       seen;
    seen = 1'b0;
    apb(1'b1, IDX_LPA, 8'h55);
    apb(1'b1, IDX_LPB, 8'hAA);
    cfg(8'h00, 8'h01, 8'h3C);
    repeat (60) begin
      @(negedge clk_i);
      if (tx_valid_o === 1'b1 && tx_out_o.chan < 5'h18) begin
        if (seen)
          check(tx_out_o.data ^ prev, 8'hFF);
        check({7'h0, tx_out_o.data inside {8'h55, 8'hAA}}, 8'h01);
        prev = tx_out_o.data;
        seen = 1'b1;
      end
    end
    $display("Loop code done");
  endtask : t_loop

  // Software signaling into channel 1 only; other channels stay clear
  task automatic t_sig;
    apb(1'b1, IDX_SSIE0, 8'h01);
    apb(1'b1, IDX_SIG0, 8'h01);
    cfg(8'h10, 8'h00, 8'h3C);
    repeat (40) begin
      @(negedge clk_i);
      if (tx_valid_o === 1'b1 && tx_out_o.chan < 5'h18)
        check(tx_out_o.data, (tx_out_o.chan == 5'h00) ? 8'h3D : 8'h3C);
    end
    apb(1'b1, IDX_SSIE0, 8'h00);
    $display("Signaling done");
  endtask : t_sig

  // Framing select and alarm code on the data link bits
  task automatic t_fdl;
    logic [7:0] tab [3] = '{8'h04, 8'h10, 8'h14};
    int nz;
    foreach (tab[i]) begin
      cfg(8'h00, tab[i], 8'h3C);
      nz = 0;
      repeat (16) begin
        tx_fdl_slot_i <= 1'b1;
        @(posedge clk_i);
        tx_fdl_slot_i <= 1'b0;
        @(negedge clk_i);
        nz += (tx_fdl_bit_o === 1'b0);
        @(posedge clk_i);
      end
      check(32'(nz), (i == 2) ? 32'h3 : 32'h0);
    end
    $display("Data link done");
  endtask : t_fdl

  task automatic t_dens;
    cfg(8'h00, 8'h00, 8'h00);
    apb(1'b0, IDX_INFO, 8'h00);
    check(rd, 32'hC0);
    cfg(8'h00, 8'h02, 8'h00);
    apb(1'b1, IDX_INFO, 8'hC0);
    apb(1'b0, IDX_INFO, 8'h00);
    check(rd, 32'h80);
    cfg(8'h00, 8'h00, 8'h01);
    apb(1'b1, IDX_INFO, 8'hC0);
    apb(1'b0, IDX_INFO, 8'h00);
    check(rd, 32'h0);
    $display("Density done");
  endtask : t_dens

  task automatic t_st4;
    rx_blue_i   <= 1'b1;
    rx_yellow_i <= 1'b1;
    rx_boc_i    <= RAICI_BOC;
    cfg(8'h00, 8'h00, AISCI_BYTE);
    apb(1'b0, IDX_ST4, 8'h00);
    check(rd, 32'h3);
    rx_blue_i <= 1'b0;
    rx_boc_i  <= 6'h00;
    repeat (4) @(posedge clk_i);
    apb(1'b0, IDX_ST4, 8'h00);
    check(rd, 32'h0);
    $display("Receive status done");
  endtask : t_st4

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    {psel_i, penable_i, pwrite_i, tx_fdl_slot_i, run, rx_blue_i, rx_yellow_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    dat = '0;
    rx_boc_i = '0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_mw;
    t_tx;
    t_ais;
    t_loop;
    t_sig;
    t_fdl;
    t_dens;
    t_st4;
    complete_run;
  end

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    complete_run;
  end
endmodule : tcm_top_bench

bind tcm_top tcm_top_assertions u_chk (.*);
